//--- rtl/crc_pkg.sv
// Constants of the core reset controller.
// Assumes a 50 MHz core clock; one machine cycle is a fixed number of clocks.
`default_nettype none
package crc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned GLITCH_NS = 50;
  // Dip must last longer than the glitch time before it counts
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_ACTIVE_MC = 2;
  localparam int unsigned CLK_PER_MC = 6;
  localparam int unsigned MIN_ACTIVE_CYC = MIN_ACTIVE_MC * CLK_PER_MC;
  localparam int unsigned PIN_PULSE_OSC = 96;
  localparam int unsigned CNT_W = 8;
  typedef enum logic [1:0] {
    CRC_HOLD = 2'h0,
    CRC_WAIT = 2'h1,
    CRC_RUN = 2'h3
  } crc_state_t;
endpackage
`default_nettype wire

//--- rtl/crc_core_reset_controller.sv
// Core reset controller: merges pin, power-on, power-fail and hang timer sources.
// Assumes the clock is the oscillator clock (one oscillator period per clk).
`default_nettype none
module crc_core_reset_controller #(
  parameter int unsigned PULSE_CYC = crc_pkg::PIN_PULSE_OSC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic supply_good,
  input wire logic osc_ready,
  input wire logic rise_release_threshold,
  input wire logic fall_hold_threshold,
  input wire logic software_hang_timer_ovf,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic core_rst
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin and analog inputs: three-stage synchronisers
  logic [2:0] pin_sync_reg;
  logic [2:0] good_sync_reg;
  logic [2:0] osc_sync_reg;
  logic [2:0] por_sync_reg;
  logic [2:0] fail_sync_reg;
  logic [2:0] pin_sync_next;
  logic [2:0] good_sync_next;
  logic [2:0] osc_sync_next;
  logic [2:0] por_sync_next;
  logic [2:0] fail_sync_next;
  logic pin_low_reg, pin_low_next;
  logic good_reg, good_next;
  logic osc_reg, osc_next;
  logic por_ok_reg, por_ok_next;
  logic fail_raw_reg, fail_raw_next;

  function automatic logic settle(input logic [2:0] s, input logic prev);
    settle = (s[1] == s[2]) ? s[1] : prev;
  endfunction

  always_comb begin
    pin_sync_next = {pin_sync_reg[1:0], reset_pin_i};
    good_sync_next = {good_sync_reg[1:0], supply_good};
    osc_sync_next = {osc_sync_reg[1:0], osc_ready};
    por_sync_next = {por_sync_reg[1:0], rise_release_threshold};
    fail_sync_next = {fail_sync_reg[1:0], fall_hold_threshold};
    pin_low_next = ~settle(pin_sync_reg, ~pin_low_reg);
    good_next = settle(good_sync_reg, good_reg);
    osc_next = settle(osc_sync_reg, osc_reg);
    por_ok_next = settle(por_sync_reg, por_ok_reg);
    fail_raw_next = settle(fail_sync_reg, fail_raw_reg);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_sync_reg <= 3'h7;
      good_sync_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
      por_sync_reg <= 3'h0;
      fail_sync_reg <= 3'h0;
      pin_low_reg <= 1'b0;
      good_reg <= 1'b0;
      osc_reg <= 1'b0;
      por_ok_reg <= 1'b0;
      fail_raw_reg <= 1'b0;
    end else begin
      pin_sync_reg <= pin_sync_next;
      good_sync_reg <= good_sync_next;
      osc_sync_reg <= osc_sync_next;
      por_sync_reg <= por_sync_next;
      fail_sync_reg <= fail_sync_next;
      pin_low_reg <= pin_low_next;
      good_reg <= good_next;
      osc_reg <= osc_next;
      por_ok_reg <= por_ok_next;
      fail_raw_reg <= fail_raw_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filter on the power-fail level
  localparam logic [crc_pkg::CNT_W-1:0] GLITCH_MAX = crc_pkg::CNT_W'(crc_pkg::GLITCH_CYC);
  logic [crc_pkg::CNT_W-1:0] dip_cnt_reg, dip_cnt_next;
  logic fail_reg, fail_next;

  always_comb begin
    dip_cnt_next = '0;
    fail_next = 1'b0;
    if (fail_raw_reg) begin
      // Only a dip outlasting the glitch time counts
      dip_cnt_next = (dip_cnt_reg > GLITCH_MAX) ? dip_cnt_reg : dip_cnt_reg + 1'b1;
      fail_next = (dip_cnt_reg >= GLITCH_MAX);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dip_cnt_reg <= '0;
      fail_reg <= 1'b0;
    end else begin
      dip_cnt_reg <= dip_cnt_next;
      fail_reg <= fail_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin pulse driven on hang timer overflow
  logic [crc_pkg::CNT_W-1:0] pulse_cnt_reg, pulse_cnt_next;

  always_comb begin
    pulse_cnt_next = pulse_cnt_reg;
    if (software_hang_timer_ovf) begin
      pulse_cnt_next = crc_pkg::CNT_W'(PULSE_CYC);
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_next = pulse_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_cnt_reg <= '0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source merge and release sequencing
  localparam logic [crc_pkg::CNT_W-1:0] MIN_CYC = crc_pkg::CNT_W'(crc_pkg::MIN_ACTIVE_CYC);
  logic req;
  logic pwr_req;
  crc_pkg::crc_state_t state_reg, state_next;
  logic [crc_pkg::CNT_W-1:0] act_cnt_reg, act_cnt_next;

  // Any source asserts the request at once
  assign pwr_req = ~por_ok_reg | fail_reg;
  assign req = pin_low_reg | pwr_req | (pulse_cnt_reg != '0) | software_hang_timer_ovf;

  always_comb begin
    state_next = state_reg;
    act_cnt_next = act_cnt_reg;
    unique case (state_reg)
      crc_pkg::CRC_HOLD: begin
        act_cnt_next = '0;
        if (!req && good_reg && osc_reg) begin
          state_next = crc_pkg::CRC_WAIT;
        end
      end
      crc_pkg::CRC_WAIT: begin
        act_cnt_next = act_cnt_reg + 1'b1;
        if (req || !good_reg || !osc_reg) begin
          state_next = crc_pkg::CRC_HOLD;
        end else if (act_cnt_reg >= MIN_CYC - 1'b1) begin
          state_next = crc_pkg::CRC_RUN;
        end
      end
      crc_pkg::CRC_RUN: begin
        if (req || !good_reg || !osc_reg) begin
          state_next = crc_pkg::CRC_HOLD;
        end
      end
      default: begin
        state_next = crc_pkg::CRC_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= crc_pkg::CRC_HOLD;
      act_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      act_cnt_reg <= act_cnt_next;
    end
  end

  // Assertion is combinational from the request; release only on a clock edge
  // Supply or oscillator loss must not wait an edge for the state to leave run
  assign core_rst = srst | req | ~good_reg | ~osc_reg | (state_reg != crc_pkg::CRC_RUN);
  // Open-drain style: only ever drives low
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = (pulse_cnt_reg != '0) | pwr_req;

  ////////////////////////////////////////////////////////////////////////////
  a_min_active: assert property (@(posedge clk) disable iff (srst)
    $rose(state_reg == crc_pkg::CRC_RUN) |-> $past(state_reg == crc_pkg::CRC_WAIT, 12))
    else $error("reset released before minimum time");
  a_supply_hold: assert property (@(posedge clk) disable iff (srst)
    !good_reg |-> core_rst)
    else $error("reset released without supply good");
  a_osc_hold: assert property (@(posedge clk) disable iff (srst)
    !osc_reg |-> core_rst)
    else $error("reset released without oscillator");
  a_pulse_load: assert property (@(posedge clk) disable iff (srst)
    software_hang_timer_ovf |=> pulse_cnt_reg == crc_pkg::CNT_W'(PULSE_CYC))
    else $error("pin pulse not restarted");
  a_pulse_step: assert property (@(posedge clk) disable iff (srst)
    !software_hang_timer_ovf && (pulse_cnt_reg != '0) |=> pulse_cnt_reg == $past(pulse_cnt_reg) - 1'b1)
    else $error("pin pulse count skipped");
  a_pulse_len: assert property (@(posedge clk) disable iff (srst)
    (pulse_cnt_reg != '0) |-> reset_pin_oe && core_rst)
    else $error("pin pulse too short");
  a_src_pin: assert property (@(posedge clk) disable iff (srst)
    pin_low_reg |-> core_rst)
    else $error("pin reset not merged");
  a_por_hold: assert property (@(posedge clk) disable iff (srst)
    !por_ok_reg |-> core_rst && reset_pin_oe)
    else $error("power-on hold missing");
  a_fail_hold: assert property (@(posedge clk) disable iff (srst)
    fail_reg |-> core_rst && reset_pin_oe)
    else $error("power-fail hold missing");
  sequence s_short_dip;
    $rose(fail_raw_reg) ##1 fail_raw_reg ##1 fail_raw_reg;
  endsequence
  a_glitch_flt: assert property (@(posedge clk) disable iff (srst)
    s_short_dip |-> !fail_reg)
    else $error("short dip caused reset");
  a_pin_low: assert property (@(posedge clk) disable iff (srst)
    reset_pin_oe |-> !reset_pin_o)
    else $error("pin driven high");
endmodule // crc_core_reset_controller
`default_nettype wire

//--- dv/crc_supply_model.sv
// Far side model: supply monitors, oscillator and reset pin with pull-up.
// Assumes the bench sets which faults are present through fault.
`default_nettype none
module crc_supply_model (
  input wire logic [4:0] fault,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  output logic supply_good,
  output logic osc_ready,
  output logic rise_release_threshold,
  output logic fall_hold_threshold,
  output logic reset_pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  assign supply_good = !fault[0];
  assign osc_ready = !fault[1];
  assign rise_release_threshold = !fault[2];
  assign fall_hold_threshold = fault[3];
  // Pull-up wins unless a party pulls low
  assign reset_pin_i = !(fault[4] || (reset_pin_oe && !reset_pin_o));
endmodule // crc_supply_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the core reset controller.
// Assumes the far side model and a short pin pulse parameter.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PULSE = 10;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic ovf = 1'h0;
  logic [4:0] fault = 5'h00;
  logic sg, osc, rise, fall, pin_i, pin_o, pin_oe, core_rst;
  int num_errors = 0;
  int n_tests = 0;
  int n;
  crc_core_reset_controller #(.PULSE_CYC(PULSE)) u_crc_core_reset_controller (.clk(clk),
    .srst(srst), .supply_good(sg), .osc_ready(osc), .rise_release_threshold(rise),
    .fall_hold_threshold(fall), .software_hang_timer_ovf(ovf), .reset_pin_i(pin_i),
    .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .core_rst(core_rst));
  crc_supply_model u_crc_supply_model (.fault(fault), .reset_pin_o(pin_o),
    .reset_pin_oe(pin_oe), .supply_good(sg), .osc_ready(osc),
    .rise_release_threshold(rise), .fall_hold_threshold(fall), .reset_pin_i(pin_i));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input string name, input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Counts held cycles; bounded so a stuck reset shows as a mismatch
  task automatic wait_release(output int c);
    c = 0;
    while (core_rst !== 1'h0 && c < 300) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h345d85ea));
    cyc(6);
    check("rst_in_srst", core_rst, 1'h1);
    srst = 1'h0;
    wait_release(n);
    check("first_release", core_rst, 1'h0);
    check("min_active", n >= crc_pkg::MIN_ACTIVE_CYC, 1'h1);
    $display("test power_up done");
    // One source at a time, random hold length
    for (int i = 0; i < 5; i++) begin
      fault[i] = 1'h1;
      cyc(8 + $urandom % 8);
      check("src_hold", core_rst, 1'h1);
      check("pin_drive", pin_oe, (i == 2 || i == 3));
      fault[i] = 1'h0;
      wait_release(n);
      check("src_release", core_rst, 1'h0);
      check("src_min", n >= crc_pkg::MIN_ACTIVE_CYC, 1'h1);
      $display("test source %0d done", i);
    end
    // Dip of two cycles lies under the filter time
    fault[3] = 1'h1;
    cyc(2);
    fault[3] = 1'h0;
    n = 0;
    repeat (12) begin
      cyc(1);
      n += core_rst;
    end
    check("glitch_ignored", n == 0, 1'h1);
    $display("test glitch done");
    ovf = 1'h1;
    cyc(1);
    ovf = 1'h0;
    check("ovf_rst", core_rst, 1'h1);
    check("pin_value", pin_o, 1'h0);
    n = 0;
    repeat (PULSE + 20) begin
      n += pin_oe;
      cyc(1);
    end
    check("pulse_len", n == PULSE, 1'h1);
    wait_release(n);
    check("ovf_release", core_rst, 1'h0);
    $display("test overflow done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
